// *** src/nms_map.svh ***
// Constants for the marker, correction summary and setup block.
`ifndef NMS_MAP_SVH
`define NMS_MAP_SVH
`define NMS_ERASED_BYTE    8'hff
`define NMS_SKIP_RST       8'h00
`define NMS_MARKER_RST     8'hff
`define NMS_WAIT_RST       16'h01f4
`define NMS_MON_RST        16'h01f4
`define NMS_DEVICES        4
`endif

// *** src/nms_pkg.sv ***
// Types for the marker, correction summary and setup block.
package nms_pkg;
  typedef enum logic [1:0] {
    NMS_MODE_MAIN  = 2'b00,
    NMS_MODE_SPARE = 2'b01,
    NMS_MODE_MS    = 2'b10
  } nms_mode_t;
  typedef enum logic [1:0] {
    NMS_ST_CLEAN   = 2'b00,
    NMS_ST_CORR    = 2'b01,
    NMS_ST_UNCORR  = 2'b10
  } nms_class_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } nms_byte_t;
  typedef struct packed {
    logic [7:0] peak_corrections;
    logic       uncorrectable_flag;
    nms_class_t status;
  } nms_summary_t;
  typedef struct packed {
    logic [15:0] load_wait;
    logic [15:0] program_wait;
    logic [15:0] erase_wait;
    logic [15:0] monitor_interval;
  } nms_poll_t;
endpackage : nms_pkg

// *** src/nms_core.sv ***
// Bad-block marker handling, correction summary and device setup holding.
// Notes on behaviour
// - Marker byte not 0xff means bad block.
// - Spare spill starts at skip count offset.
// - Skip count resets zero; zero skips nothing.
// - Main mode writes fill value into skipped bytes.
// - Fill value is an eight-bit field.
// - Spare mode passes data unchanged both ways.
// - Main+spare keeps host marker bytes, spill not offset.
// - Report peak corrections of any sector.
// - Classify transaction uncorrectable, correctable or clean.
// - Per-device ready/busy or polling selection bit.
// - Polling uses programmable wait cycle counts.
// - Boot preset sets two-row-address flag once after reset release.
// - Main mode with ECC strips check bytes on reads.
`timescale 1ns/100ps
`include "nms_map.svh"
module nms_core (
  input  wire logic                   core_clk,          // Controller clock, 25 MHz.
  input  wire logic                   rst_n,             // Synchronous reset, active low.
  input  wire logic                   clk_en,            // Freezes all state while low.
  input  wire nms_pkg::nms_mode_t     xfer_mode,         // Page transfer mode.
  input  wire logic                   ecc_enable,        // ECC engine enabled.
  input  wire logic                   page_write,        // High for a page write.
  input  wire logic [7:0]             skip_bytes_in,     // Marker skip count setting.
  input  wire logic [7:0]             marker_in,         // Marker fill value setting.
  input  wire logic                   cfg_write,         // Load skip and fill settings.
  input  wire logic                   in_spare,          // Stream position is in spare.
  input  wire logic [7:0]             spare_offset,      // Byte offset in spare area.
  input  wire logic                   ecc_byte,          // Current byte is ECC check.
  input  wire nms_pkg::nms_byte_t     up_byte,           // Byte arriving from source.
  output nms_pkg::nms_byte_t          dn_byte,           // Byte sent toward target.
  output logic                        stream_hold,       // Source holds byte this cycle.
  input  wire logic                   marker_check,      // Current read byte is a marker.
  output logic                        bad_block,         // Sticky bad-marker seen.
  input  wire logic                   xact_start,        // New transaction begins.
  input  wire logic                   sector_done,       // Sector correction result valid.
  input  wire logic [7:0]             sector_corr,       // Corrections in that sector.
  input  wire logic                   sector_uncorr,     // Sector uncorrectable.
  input  wire logic                   xact_end,          // Correction of transaction done.
  output nms_pkg::nms_summary_t       correction_summary, // Per-transaction summary.
  output logic                        summary_valid,     // Summary complete.
  input  wire logic [`NMS_DEVICES-1:0] readybusy_in,     // Per-device selection setting.
  input  wire logic [`NMS_DEVICES-1:0] dev_idle,         // Device has nothing outstanding.
  input  wire logic                   rb_write,          // Load selection setting.
  output logic [`NMS_DEVICES-1:0]     readybusy_select,  // 1 selects ready/busy pin.
  input  wire nms_pkg::nms_poll_t     poll_in,           // Polling counts setting.
  input  wire logic                   poll_write,        // Load polling counts.
  output nms_pkg::nms_poll_t          poll_cfg,          // Held polling counts.
  input  wire logic [1:0]             poll_kind,         // 0 load, 1 program, 2 erase.
  input  wire logic                   poll_start,        // Begin a status-poll wait.
  output logic                        poll_issue,        // Pulse: issue status read.
  input  wire logic                   boot_two_row,      // Boot preset pin.
  input  wire logic                   two_row_wr,        // Write two-row flag.
  input  wire logic                   two_row_val,       // Value for two-row flag.
  output logic                        two_row_flag       // Two row address cycles.
);
  import nms_pkg::*;

  logic [7:0]   skip_ff;
  logic [7:0]   marker_ff;
  nms_byte_t    dn_ff;
  logic         bad_ff;
  nms_summary_t sum_ff;
  logic         sumv_ff;
  logic [3:0]   rbsel_ff;
  nms_poll_t    poll_ff;
  logic [15:0]  pcnt_ff;
  logic         pbusy_ff;
  logic         pissue_ff;
  logic         two_ff;
  logic         boot_s1_ff;
  logic         boot_s2_ff;
  logic         init_ff;

  function automatic logic [7:0] max8(input logic [7:0] a, input logic [7:0] b);
    max8 = (a > b) ? a : b;
  endfunction : max8

  // Skip window applies only to spare bytes of main-style writes.
  wire in_skip   = page_write && in_spare && (spare_offset < skip_ff);
  wire mode_main = (xfer_mode == NMS_MODE_MAIN);
  wire mode_ms   = (xfer_mode == NMS_MODE_MS);
  // Main mode overwrites the marker window with the fill value.
  wire fill_now  = mode_main && in_skip;
  // Main+spare never holds the source and passes the window through as host data; the spill
  // start is therefore not delayed by the skip count. Markers are the host's bytes.
  wire strip_now = mode_main && ecc_enable && ecc_byte && !page_write;
  wire drop_byte = strip_now;
  assign stream_hold = fill_now;
  wire [7:0] out_data = fill_now ? marker_ff : up_byte.data;
  wire       out_vld  = fill_now | (up_byte.valid & ~drop_byte);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      skip_ff   <= `NMS_SKIP_RST;
      marker_ff <= `NMS_MARKER_RST;
    end else if (clk_en && cfg_write) begin
      skip_ff   <= skip_bytes_in;
      marker_ff <= marker_in;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dn_ff <= '0;
    end else if (clk_en) begin
      dn_ff <= '{valid: out_vld, data: out_data};
    end
  end
  assign dn_byte = dn_ff;

  // Any marker other than erased flags a bad block; cleared at transaction start.
  wire bad_hit = marker_check && up_byte.valid && (up_byte.data != `NMS_ERASED_BYTE);
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bad_ff <= 1'b0;
    end else if (clk_en) begin
      bad_ff <= bad_hit | (bad_ff & ~xact_start);
    end
  end
  assign bad_block = bad_ff;

  // A sector result in the start cycle belongs to the new transaction.
  wire [7:0] base_peak = xact_start ? 8'h00 : sum_ff.peak_corrections;
  wire       base_unc  = xact_start ? 1'b0 : sum_ff.uncorrectable_flag;
  wire       base_cor  = xact_start ? 1'b0 : (sum_ff.status == NMS_ST_CORR);
  wire [7:0] nxt_peak  = sector_done ? max8(base_peak, sector_corr) : base_peak;
  wire       nxt_unc   = base_unc | (sector_done & sector_uncorr);
  wire       nxt_cor   = base_cor | (sector_done & ~sector_uncorr & (sector_corr != 8'h00));
  wire nms_class_t nxt_cls = nxt_unc ? NMS_ST_UNCORR :
                             (nxt_cor ? NMS_ST_CORR : NMS_ST_CLEAN);
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sum_ff  <= '0;
      sumv_ff <= 1'b0;
    end else if (clk_en) begin
      sum_ff  <= '{peak_corrections: nxt_peak, uncorrectable_flag: nxt_unc, status: nxt_cls};
      sumv_ff <= xact_end | (sumv_ff & ~xact_start);
    end
  end
  assign correction_summary = sum_ff;
  assign summary_valid      = sumv_ff;

  // Only idle devices take a new selection, which keeps in-flight waits consistent.
  wire [3:0] nxt_rbsel = (readybusy_in & dev_idle) | (rbsel_ff & ~dev_idle);
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rbsel_ff <= 4'h0;
      poll_ff  <= '{`NMS_WAIT_RST, `NMS_WAIT_RST, `NMS_WAIT_RST, `NMS_MON_RST};
    end else if (clk_en) begin
      if (rb_write) begin
        rbsel_ff <= nxt_rbsel;
      end
      if (poll_write) begin
        poll_ff <= poll_in;
      end
    end
  end
  assign readybusy_select = rbsel_ff;
  assign poll_cfg         = poll_ff;

  // First wait uses the operation count, repeats use the monitor interval.
  wire [15:0] first_cnt = (poll_kind == 2'd0) ? poll_ff.load_wait :
                          (poll_kind == 2'd1) ? poll_ff.program_wait :
                          poll_ff.erase_wait;
  wire        pexp      = pbusy_ff && (pcnt_ff <= 16'h0001);
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pcnt_ff   <= 16'h0000;
      pbusy_ff  <= 1'b0;
      pissue_ff <= 1'b0;
    end else if (clk_en) begin
      pissue_ff <= pexp;
      if (poll_start) begin
        pbusy_ff <= 1'b1;
        pcnt_ff  <= first_cnt;
      end else if (pexp) begin
        pcnt_ff  <= poll_ff.monitor_interval;
      end else if (pbusy_ff) begin
        pcnt_ff  <= pcnt_ff - 16'h0001;
      end
    end
  end
  assign poll_issue = pissue_ff;

  // The preset synchroniser keeps running through reset. Were it cleared with the rest,
  // the single sample taken after release would always see zero and lose the preset.
  always_ff @(posedge core_clk) begin
    if (clk_en) begin
      boot_s1_ff <= boot_two_row;
      boot_s2_ff <= boot_s1_ff;
    end
  end

  // Boot preset is a pin, so only its synchronised copy is sampled once after release.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      init_ff    <= 1'b1;
      two_ff     <= 1'b0;
    end else if (clk_en) begin
      init_ff    <= 1'b0;
      if (two_row_wr) begin
        two_ff <= two_row_val;
      end else if (init_ff) begin
        two_ff <= boot_s2_ff;
      end
    end
  end
  assign two_row_flag = two_ff;

  fill_marker_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && fill_now) |=> (dn_byte.valid && dn_byte.data == $past(marker_ff)))
    else $error("fill value not written in main mode");
  spare_pass_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && xfer_mode == NMS_MODE_SPARE) |=> (dn_byte == $past(up_byte)))
    else $error("spare mode altered data");
  ms_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && mode_ms) |=> (dn_byte == $past(up_byte)))
    else $error("main+spare altered host bytes");
  skip_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (skip_ff == 8'h00) |-> !stream_hold)
    else $error("bytes skipped with zero count");
  bad_mark_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && bad_hit) |=> bad_block)
    else $error("bad marker missed");
  peak_max_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && sector_done) |=> (correction_summary.peak_corrections >= $past(sector_corr)))
    else $error("peak below sector count");
  uncorr_cls_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && sector_done && sector_uncorr) |=>
      (correction_summary.status == NMS_ST_UNCORR))
    else $error("uncorrectable sector not classified");
  start_clr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && xact_start && !sector_done) |=>
      (correction_summary == '0 && !summary_valid))
    else $error("summary not cleared at start");
  strip_ecc_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && strip_now && !fill_now) |=> !dn_byte.valid)
    else $error("check byte not stripped");
  rb_busy_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && rb_write && dev_idle == 4'h0) |=> $stable(readybusy_select))
    else $error("busy device changed mode");
  boot_two_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && init_ff && !two_row_wr) |=> (two_row_flag == $past(boot_s2_ff)))
    else $error("boot preset not applied");

  // Steps of the correction summary and polling behaviour.
  sequence sec_corr_s;
    clk_en && sector_done && (sector_corr != 8'h00);
  endsequence
  sequence xact_end_s;
    clk_en && xact_end && !xact_start;
  endsequence
  sequence poll_expire_s;
    clk_en && pexp && !poll_start;
  endsequence
  property corr_seen_p;
    @(posedge core_clk) disable iff (!rst_n)
      sec_corr_s |=> (correction_summary.status != NMS_ST_CLEAN);
  endproperty
  property end_valid_p;
    @(posedge core_clk) disable iff (!rst_n)
      xact_end_s |=> summary_valid;
  endproperty
  property poll_reload_p;
    @(posedge core_clk) disable iff (!rst_n)
      poll_expire_s |=> (pcnt_ff == $past(poll_ff.monitor_interval));
  endproperty

  corr_class_a: assert property (corr_seen_p)
    else $error("corrected sector left summary clean");
  end_valid_a: assert property (end_valid_p)
    else $error("summary not valid after end");
  poll_reload_a: assert property (poll_reload_p)
    else $error("monitor interval not reloaded");
  poll_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && pexp) |=> poll_issue)
    else $error("status read not issued");
  bad_sticky_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && bad_block && !xact_start) |=> bad_block)
    else $error("bad block flag lost");
  unc_sticky_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && correction_summary.uncorrectable_flag && !xact_start) |=>
      (correction_summary.status == NMS_ST_UNCORR))
    else $error("uncorrectable class lost");
  freeze_state_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !clk_en |=> ($stable(dn_byte) && $stable(correction_summary) && $stable(two_row_flag)))
    else $error("state moved while frozen");
endmodule : nms_core

// *** dv/nms_flash_model.sv ***
// Far-side flash model: keeps the spare bytes written and returns them on reads.
`timescale 1ns/100ps
`include "nms_map.svh"
module nms_flash_model (
  input  wire logic               core_clk,     // Controller clock.
  input  wire nms_pkg::nms_byte_t dn_byte,      // Byte arriving from the controller.
  input  wire logic               page_write,   // High while a page is written.
  input  wire logic [7:0]         spare_offset, // Spare offset of the current byte.
  output logic [7:0]              rd_byte       // Stored byte at the current offset.
);
  import nms_pkg::*;
  logic [7:0] mem_ff [0:63];
  logic [7:0] off_ff;
  logic       wr_ff;
  // Erased cells read back as all ones, the good-block value.
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem_ff[i] = `NMS_ERASED_BYTE;
    end
  end
  // The output byte lags its position by one cycle, so position is delayed to match.
  always @(posedge core_clk) begin
    off_ff <= spare_offset;
    wr_ff <= page_write;
    if (dn_byte.valid && wr_ff) begin
      mem_ff[off_ff[5:0]] <= dn_byte.data;
    end
  end
  assign rd_byte = mem_ff[spare_offset[5:0]];
endmodule : nms_flash_model

// *** dv/tb_nms_core.sv ***
// Self-checking bench for the marker, correction summary and setup block.
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb_nms_core;
  import nms_pkg::*;
  logic         core_clk = 1'b0, rst_n = 1'b0, ecc_enable = 1'b1, page_write = 1'b0;
  logic [7:0]   skip_bytes_in = 8'h00, marker_in = 8'h00, spare_offset = 8'h00;
  logic [7:0]   sector_corr = 8'h00, flash_rd;
  logic         cfg_write = 1'b0, in_spare = 1'b0, ecc_byte = 1'b0, marker_check = 1'b0;
  logic         xact_start = 1'b0, sector_done = 1'b0, sector_uncorr = 1'b0, xact_end = 1'b0;
  logic [3:0]   readybusy_in = 4'h0, dev_idle = 4'h0, readybusy_select;
  logic         rb_write = 1'b0, poll_write = 1'b0, poll_start = 1'b0, poll_issue;
  logic [1:0]   poll_kind = 2'h0;
  logic         boot_two_row = 1'b1, two_row_wr = 1'b0, two_row_val = 1'b0, two_row_flag;
  logic         stream_hold, bad_block, summary_valid, h, clk_en = 1'b1;
  nms_mode_t    xfer_mode = NMS_MODE_MAIN;
  nms_byte_t    up_byte = '0, dn_byte, o;
  nms_summary_t correction_summary;
  nms_poll_t    poll_in = '0, poll_cfg;
  int           errors = 0, comparisons = 0, n;
  always #20 core_clk = ~core_clk;
  nms_core u_dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .xfer_mode(xfer_mode),
    .ecc_enable(ecc_enable), .page_write(page_write), .skip_bytes_in(skip_bytes_in),
    .marker_in(marker_in), .cfg_write(cfg_write), .in_spare(in_spare),
    .spare_offset(spare_offset), .ecc_byte(ecc_byte), .up_byte(up_byte), .dn_byte(dn_byte),
    .stream_hold(stream_hold), .marker_check(marker_check), .bad_block(bad_block),
    .xact_start(xact_start), .sector_done(sector_done), .sector_corr(sector_corr),
    .sector_uncorr(sector_uncorr), .xact_end(xact_end), .summary_valid(summary_valid),
    .correction_summary(correction_summary), .readybusy_in(readybusy_in),
    .dev_idle(dev_idle), .rb_write(rb_write), .readybusy_select(readybusy_select),
    .poll_in(poll_in), .poll_write(poll_write), .poll_cfg(poll_cfg), .poll_kind(poll_kind),
    .poll_start(poll_start), .poll_issue(poll_issue), .boot_two_row(boot_two_row),
    .two_row_wr(two_row_wr), .two_row_val(two_row_val), .two_row_flag(two_row_flag));
  nms_flash_model u_flash (.core_clk(core_clk), .dn_byte(dn_byte), .page_write(page_write),
    .spare_offset(spare_offset), .rd_byte(flash_rd));
  task automatic stop_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test
  // One stream byte: hold is read in the launch cycle, the output byte one cycle later.
  task automatic send(input nms_mode_t m, input logic w, sp, ecc, k,
                      input logic [7:0] off, d, output logic hh, output nms_byte_t oo);
    @(posedge core_clk);
    xfer_mode <= m;
    page_write <= w;
    in_spare <= sp;
    ecc_byte <= ecc;
    marker_check <= k;
    spare_offset <= off;
    up_byte <= '{1'b1, d};
    #1 hh = stream_hold;
    @(posedge core_clk);
    #1 oo = dn_byte;
  endtask : send
  task automatic load(input logic [7:0] s, mk, input logic [3:0] rb, idle,
                      input nms_poll_t p, input logic tr);
    @(posedge core_clk);
    up_byte <= '0;
    marker_check <= 1'b0;
    skip_bytes_in <= s;
    marker_in <= mk;
    readybusy_in <= rb;
    dev_idle <= idle;
    poll_in <= p;
    two_row_val <= tr;
    {cfg_write, rb_write, poll_write, two_row_wr} <= 4'hf;
    @(posedge core_clk);
    {cfg_write, rb_write, poll_write, two_row_wr} <= 4'h0;
    #1;
  endtask : load
  task automatic xact(input logic [7:0] c0, input logic u0, input logic [7:0] c1,
                      input logic u1, input nms_summary_t exp);
    @(posedge core_clk);
    up_byte <= '0;
    marker_check <= 1'b0;
    xact_start <= 1'b1;
    @(posedge core_clk);
    xact_start <= 1'b0;
    sector_done <= 1'b1;
    sector_corr <= c0;
    sector_uncorr <= u0;
    @(posedge core_clk);
    sector_corr <= c1;
    sector_uncorr <= u1;
    @(posedge core_clk);
    sector_done <= 1'b0;
    xact_end <= 1'b1;
    @(posedge core_clk);
    xact_end <= 1'b0;
    #1;
    `CHK("summary_valid", 1'b1, summary_valid)
    `CHK("summary", exp, correction_summary)
  endtask : xact
  initial begin
    #2000000;
    errors++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    `CHK("poll_cfg", {4{16'h01f4}}, poll_cfg)
    `CHK("select", 4'h0, readybusy_select)
    `CHK("two_row", 1'b1, two_row_flag)
    send(NMS_MODE_MAIN, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00, 8'h3c, h, o);
    `CHK("hold", 1'b0, h)
    `CHK("dn", 9'h13c, o)
    load(8'h02, 8'ha5, 4'hf, 4'h3, '{16'h3, 16'h7, 16'h9, 16'h5}, 1'b0);
    `CHK("select", 4'h3, readybusy_select)
    `CHK("poll_cfg", {16'h3, 16'h7, 16'h9, 16'h5}, poll_cfg)
    `CHK("two_row", 1'b0, two_row_flag)
    for (int i = 0; i < 3; i++) begin
      send(NMS_MODE_MAIN, 1'b1, 1'b1, 1'b0, 1'b0, 8'(i), 8'h10 + 8'(i), h, o);
      `CHK("hold", i < 2, h)
      `CHK("dn", {1'b1, (i < 2) ? 8'ha5 : 8'h12}, o)
    end
    send(NMS_MODE_SPARE, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00, h, o);
    `CHK("spare", {1'b0, 9'h100}, {h, o})
    send(NMS_MODE_MS, 1'b1, 1'b1, 1'b0, 1'b0, 8'h01, 8'h77, h, o);
    `CHK("main_spare", {1'b0, 9'h177}, {h, o})
    send(NMS_MODE_MAIN, 1'b0, 1'b1, 1'b1, 1'b0, 8'h02, 8'h66, h, o);
    `CHK("ecc_valid", 1'b0, o.valid)
    send(NMS_MODE_MAIN, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 8'h5a, h, o);
    `CHK("read", {1'b0, 9'h15a}, {h, o})
    send(NMS_MODE_SPARE, 1'b0, 1'b1, 1'b0, 1'b1, 8'h00, flash_rd, h, o);
    `CHK("bad_block", 1'b1, bad_block)
    xact(8'h03, 1'b0, 8'h05, 1'b0, {8'h05, 1'b0, NMS_ST_CORR});
    `CHK("bad_clear", 1'b0, bad_block)
    send(NMS_MODE_SPARE, 1'b0, 1'b1, 1'b0, 1'b1, 8'h00, 8'hff, h, o);
    `CHK("good_block", 1'b0, bad_block)
    xact(8'h02, 1'b0, 8'h01, 1'b1, {8'h02, 1'b1, NMS_ST_UNCORR});
    xact(8'h00, 1'b0, 8'h00, 1'b0, {8'h00, 1'b0, NMS_ST_CLEAN});
    load(8'h00, 8'hff, 4'h4, 4'hf, '{16'h3, 16'h7, 16'h9, 16'h5}, 1'b1);
    `CHK("select", 4'h4, readybusy_select)
    `CHK("two_row", 1'b1, two_row_flag)
    load(8'h00, 8'hff, 4'hb, 4'h0, '{16'h3, 16'h7, 16'h9, 16'h5}, 1'b1);
    `CHK("select_busy", 4'h4, readybusy_select)
    @(posedge core_clk);
    poll_kind <= 2'h0;
    poll_start <= 1'b1;
    n = 0;
    while (n < 20 && poll_issue !== 1'b1) begin
      @(posedge core_clk);
      poll_start <= 1'b0;
      #1 n++;
    end
    `CHK("poll_wait", 4, n)
    @(posedge core_clk);
    clk_en <= 1'b0;
    two_row_wr <= 1'b1;
    two_row_val <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    `CHK("freeze", 1'b1, two_row_flag)
    @(posedge core_clk);
    clk_en <= 1'b1;
    two_row_wr <= 1'b0;
    stop_test();
  end
endmodule : tb_nms_core
